// *** dtm_pkg.sv ***
/*
 * Package for the dual channel torque cut-off monitor: timing constants,
 * error codes and the packed carriers shared by the monitor.
 * Assumes a 100 MHz system clock; times stay in milliseconds and CYC_PER_MS gives the cycles per millisecond.
 */
package dtm_pkg;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_HZ = 100_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int SKEW_TOL_MS = 120;
	localparam int SHUT_MIN_MS = 190;
	localparam int SHUT_MAX_MS = 1480;
	localparam int SHUT_TYP_MS = 630;
	localparam int MISMATCH_MAX_MS = 1600;
	localparam int TRAVEL_CHECK_MS = 2500;
	localparam int INTERRUPT_MS = 200;
	localparam int MS_CNT_W = 24;

	// ************************************************************
	// Error codes
	// ************************************************************
	localparam logic [9:0] ERR_NONE = 10'h000;
	localparam logic [9:0] ERR_SKEW_WARN = 10'h215;
	localparam logic [9:0] ERR_DIAG_SHUT = 10'h3C0;
	localparam logic [9:0] ERR_REMAINS = 10'h15C;
	localparam logic [9:0] ERR_MISSING = 10'h214;
	localparam logic [9:0] ERR_NO_TRAVEL = 10'h15D;
	localparam logic [9:0] ERR_INTERRUPT = 10'h213;

	// ************************************************************
	// Carriers
	// ************************************************************
	typedef struct packed {
		logic chan_a;
		logic chan_b;
	} dtm_chan_t;

	typedef struct packed {
		logic skew_warn;
		logic diag_shut;
		logic remains;
		logic missing;
		logic no_travel;
		logic interrupt;
	} dtm_err_t;

	typedef enum logic [1:0] {
		DTM_EQUAL = 2'b00,
		DTM_SKEW = 2'b01,
		DTM_WARNED = 2'b10,
		DTM_LOCKED = 2'b11
	} dtm_diag_t;

endpackage

// *** dtm_monitor.sv ***
/*
 * Dual channel torque cut-off monitor: gates the power stage on two enable
 * channels, compares them, locks on a persistent mismatch and runs the
 * per-journey plausibility checks.
 * Assumes inputs synchronous to clock_in and power_on_reset_in asserted only
 * at power-up; reset_in is the ordinary reset and cannot release the lock.
 */
// How it works
// - Gate drive is enabled only while both channels are high and no lock exists.
// - With both channels low the cut-off state is active and all gate drives stay off.
// - The channels are compared all the time and a mismatch or internal fault forces the drive off.
// - Channel skew up to 120 ms is tolerated and longer skew raises warning 533.
// - A mismatch lasting past the warning shuts down with error 960 after 190 to 1480 ms, typically 630 ms.
// - A channel mismatch ends in safe shutdown within 1600 ms.
// - An internal fault or error 960 locks the device and only a power cycle clears it; errors 348, 532, 349 and 531 only latch.
// - A non-safety status output shows whether cut-off is active.
// - Cut-off applies no braking, it only withholds energy.
// - Both channels still low 2.5 s after travel start raise error 348.
// - Both channels still high 2.5 s after travel end raise error 532.
// - Both channels high at standstill without travel within 2.5 s raise error 349.
// - Channels dropped during travel raise error 531 after 200 ms.
`timescale 1ns/1ps
module dtm_monitor #(
	parameter int CYC_PER_MS = dtm_pkg::CYC_PER_MS
) (
	// Clock and resets
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic power_on_reset_in,
	// Safety inputs and travel state
	input wire dtm_pkg::dtm_chan_t torque_enable_in,
	input wire logic travel_in,
	input wire logic internal_fault_in,
	// Power stage
	output logic gate_enable_out,
	output logic brake_drive_out,
	// Status and errors
	output logic cutoff_state_indicator_out,
	output logic locked_out,
	output dtm_pkg::dtm_err_t error_out,
	output logic [9:0] error_code_out
);

	localparam logic [dtm_pkg::MS_CNT_W-1:0] SKEW_MS = dtm_pkg::MS_CNT_W'(dtm_pkg::SKEW_TOL_MS);
	localparam logic [dtm_pkg::MS_CNT_W-1:0] SHUT_MS = dtm_pkg::MS_CNT_W'(dtm_pkg::SHUT_TYP_MS);
	localparam logic [dtm_pkg::MS_CNT_W-1:0] CHECK_MS = dtm_pkg::MS_CNT_W'(dtm_pkg::TRAVEL_CHECK_MS);
	localparam logic [dtm_pkg::MS_CNT_W-1:0] INTR_MS = dtm_pkg::MS_CNT_W'(dtm_pkg::INTERRUPT_MS);
	localparam logic [31:0] PRESCALE_TOP = 32'(CYC_PER_MS - 1);

	// ************************************************************
	// Millisecond tick
	// ************************************************************
	logic [31:0] prescale, next_prescale;
	logic ms_tick, next_ms_tick;

	always_comb begin
		next_ms_tick = (prescale == PRESCALE_TOP);
		next_prescale = next_ms_tick ? 32'h0000_0000 : prescale + 32'h0000_0001;
	end

	always_ff @(posedge clock_in) begin
		if (reset_in || power_on_reset_in) begin
			prescale <= 32'h0000_0000;
			ms_tick <= 1'b0;
		end else begin
			prescale <= next_prescale;
			ms_tick <= next_ms_tick;
		end
	end

	// ************************************************************
	// Channel comparison and lock
	// ************************************************************
	// The lock survives reset_in on purpose: only a power cycle may release it.
	dtm_pkg::dtm_diag_t diag, next_diag;
	logic [dtm_pkg::MS_CNT_W-1:0] diag_ms, next_diag_ms;
	logic mismatch;
	logic warn_set, shut_set;

	always_comb begin
		mismatch = torque_enable_in.chan_a ^ torque_enable_in.chan_b;
		next_diag = diag;
		next_diag_ms = diag_ms;
		warn_set = 1'b0;
		shut_set = 1'b0;
		unique case (diag)
			dtm_pkg::DTM_EQUAL: begin
				next_diag_ms = '0;
				if (internal_fault_in) begin
					next_diag = dtm_pkg::DTM_LOCKED;
					shut_set = 1'b1;
				end else if (mismatch) begin
					next_diag = dtm_pkg::DTM_SKEW;
				end
			end
			dtm_pkg::DTM_SKEW: begin
				if (internal_fault_in) begin
					next_diag = dtm_pkg::DTM_LOCKED;
					shut_set = 1'b1;
				end else if (!mismatch) begin
					next_diag = dtm_pkg::DTM_EQUAL;
				end else if (ms_tick) begin
					if (diag_ms == SKEW_MS) begin
						next_diag = dtm_pkg::DTM_WARNED;
						next_diag_ms = '0;
						warn_set = 1'b1;
					end else begin
						next_diag_ms = diag_ms + 1'b1;
					end
				end
			end
			dtm_pkg::DTM_WARNED: begin
				// Shutdown at 630 ms after the warning: 120 + 630 stays within 1600 ms
				if (internal_fault_in) begin
					next_diag = dtm_pkg::DTM_LOCKED;
					shut_set = 1'b1;
				end else if (!mismatch) begin
					next_diag = dtm_pkg::DTM_EQUAL;
				end else if (ms_tick) begin
					if (diag_ms == SHUT_MS - 1'b1) begin
						next_diag = dtm_pkg::DTM_LOCKED;
						shut_set = 1'b1;
					end else begin
						next_diag_ms = diag_ms + 1'b1;
					end
				end
			end
			dtm_pkg::DTM_LOCKED: begin
				next_diag = dtm_pkg::DTM_LOCKED;
			end
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (power_on_reset_in) begin
			diag <= dtm_pkg::DTM_EQUAL;
			diag_ms <= '0;
		end else begin
			diag <= next_diag;
			diag_ms <= next_diag_ms;
		end
	end

	// ************************************************************
	// Journey plausibility
	// ************************************************************
	logic travel_prev, next_travel_prev;
	logic [dtm_pkg::MS_CNT_W-1:0] start_ms, next_start_ms;
	logic [dtm_pkg::MS_CNT_W-1:0] end_ms, next_end_ms;
	logic [dtm_pkg::MS_CNT_W-1:0] idle_ms, next_idle_ms;
	logic [dtm_pkg::MS_CNT_W-1:0] intr_ms, next_intr_ms;
	logic start_arm, next_start_arm;
	logic end_arm, next_end_arm;
	logic idle_arm, next_idle_arm;
	logic both_hi, both_lo;
	logic hi_prev, next_hi_prev;
	dtm_pkg::dtm_err_t next_err;
	logic [9:0] next_code;

	always_comb begin
		both_hi = torque_enable_in.chan_a & torque_enable_in.chan_b;
		both_lo = !(torque_enable_in.chan_a | torque_enable_in.chan_b);
		next_travel_prev = travel_in;
		next_start_arm = start_arm;
		next_end_arm = end_arm;
		next_idle_arm = idle_arm;
		next_start_ms = start_ms;
		next_end_ms = end_ms;
		next_idle_ms = idle_ms;
		next_intr_ms = intr_ms;
		next_err = error_out;
		next_code = error_code_out;
		if (travel_in && !travel_prev) begin
			next_start_arm = 1'b1;
			next_start_ms = '0;
			next_end_arm = 1'b0;
		end
		if (!travel_in && travel_prev) begin
			next_end_arm = 1'b1;
			next_end_ms = '0;
			next_start_arm = 1'b0;
		end
		if (!start_arm || !both_lo) next_start_arm = (travel_in && !travel_prev) ? 1'b1 : 1'b0;
		if (!end_arm || !both_hi) next_end_arm = (!travel_in && travel_prev) ? 1'b1 : 1'b0;
		// Standstill watch starts when both channels rise with no travel; high after a journey is the end check's
		next_hi_prev = both_hi;
		if (travel_in || !both_hi) begin
			next_idle_arm = 1'b0;
			next_idle_ms = '0;
		end else if (!hi_prev) begin
			next_idle_arm = 1'b1;
		end
		if (ms_tick) begin
			if (start_arm && both_lo) begin
				if (start_ms == CHECK_MS - 1'b1) begin
					next_err.remains = 1'b1;
					next_code = dtm_pkg::ERR_REMAINS;
					next_start_arm = 1'b0;
				end else next_start_ms = start_ms + 1'b1;
			end
			if (end_arm && both_hi) begin
				if (end_ms == CHECK_MS - 1'b1) begin
					next_err.missing = 1'b1;
					next_code = dtm_pkg::ERR_MISSING;
					next_end_arm = 1'b0;
				end else next_end_ms = end_ms + 1'b1;
			end
			if (idle_arm && !travel_in && both_hi && idle_ms != CHECK_MS) begin
				next_idle_ms = idle_ms + 1'b1;
				if (idle_ms == CHECK_MS - 1'b1) begin
					next_err.no_travel = 1'b1;
					next_code = dtm_pkg::ERR_NO_TRAVEL;
				end
			end
		end
		// Interruption: travel active and channels dropped
		if (!travel_in || !both_lo || start_arm) begin
			next_intr_ms = '0;
		end else if (ms_tick && intr_ms != INTR_MS) begin
			next_intr_ms = intr_ms + 1'b1;
			if (intr_ms == INTR_MS - 1'b1) begin
				next_err.interrupt = 1'b1;
				next_code = dtm_pkg::ERR_INTERRUPT;
			end
		end
		if (warn_set) begin
			next_err.skew_warn = 1'b1;
			next_code = dtm_pkg::ERR_SKEW_WARN;
		end
		if (shut_set) begin
			next_err.diag_shut = 1'b1;
			next_code = dtm_pkg::ERR_DIAG_SHUT;
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in || power_on_reset_in) begin
			travel_prev <= 1'b0;
			start_arm <= 1'b0;
			end_arm <= 1'b0;
			idle_arm <= 1'b0;
			hi_prev <= 1'b0;
			start_ms <= '0;
			end_ms <= '0;
			idle_ms <= '0;
			intr_ms <= '0;
		end else begin
			travel_prev <= next_travel_prev;
			start_arm <= next_start_arm;
			end_arm <= next_end_arm;
			idle_arm <= next_idle_arm;
			hi_prev <= next_hi_prev;
			start_ms <= next_start_ms;
			end_ms <= next_end_ms;
			idle_ms <= next_idle_ms;
			intr_ms <= next_intr_ms;
		end
	end

	// Latched errors and the lock flag ignore reset_in: only a power cycle clears them
	always_ff @(posedge clock_in) begin
		if (power_on_reset_in) begin
			error_out <= '0;
			error_code_out <= dtm_pkg::ERR_NONE;
			locked_out <= 1'b0;
		end else begin
			error_out <= next_err;
			error_code_out <= next_code;
			locked_out <= (next_diag == dtm_pkg::DTM_LOCKED);
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	logic next_gate, next_cutoff;

	always_comb begin
		next_gate = torque_enable_in.chan_a && torque_enable_in.chan_b && (next_diag != dtm_pkg::DTM_LOCKED);
		next_cutoff = !next_gate;
	end

	always_ff @(posedge clock_in) begin
		if (reset_in || power_on_reset_in) begin
			gate_enable_out <= 1'b0;
			brake_drive_out <= 1'b0;
			cutoff_state_indicator_out <= 1'b1;
		end else begin
			gate_enable_out <= next_gate;
			brake_drive_out <= 1'b0;
			cutoff_state_indicator_out <= next_cutoff;
		end
	end

endmodule // dtm_monitor

// *** dtm_monitor_props.sv ***
/*
 * Checker for the torque cut-off monitor: gating, locking and timing relations.
 * Assumes it is bound onto dtm_monitor and given the same CYC_PER_MS.
 */
`timescale 1ns/1ps
module dtm_monitor_props #(
	parameter int CYC_PER_MS = 10
) (
	// Clock and resets
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic power_on_reset_in,
	// Inputs
	input wire dtm_pkg::dtm_chan_t torque_enable_in,
	input wire logic travel_in,
	input wire logic internal_fault_in,
	// Outputs
	input wire logic gate_enable_out,
	input wire logic brake_drive_out,
	input wire logic cutoff_state_indicator_out,
	input wire logic locked_out,
	input wire dtm_pkg::dtm_err_t error_out,
	input wire logic [9:0] error_code_out
);
	// ************************************************************
	// Ages of the mismatch and of the warning
	// ************************************************************
	int mis_cnt;
	int warn_age;
	int next_mis_cnt;
	int next_warn_age;
	logic any_rst;
	assign any_rst = reset_in | power_on_reset_in;
	always_comb begin
		next_mis_cnt = (torque_enable_in.chan_a != torque_enable_in.chan_b) ? mis_cnt + 1 : 0;
		next_warn_age = error_out.skew_warn ? warn_age + 1 : 0;
	end
	// Both ages survive an ordinary reset, as the diagnostic state does
	always_ff @(posedge clock_in) begin
		mis_cnt <= power_on_reset_in ? 0 : next_mis_cnt;
		warn_age <= power_on_reset_in ? 0 : next_warn_age;
	end
	// ************************************************************
	// Properties
	// ************************************************************
	default clocking @(posedge clock_in); endclocking
	default disable iff (any_rst);
	sequence s_warn;
		$rose(error_out.skew_warn);
	endsequence
	sequence s_shut;
		$rose(error_out.diag_shut);
	endsequence
	// Shutdown that follows the skew warning, not one caused by an internal fault
	sequence s_diag_shut;
		s_shut ##0 (error_out.skew_warn && !$past(internal_fault_in));
	endsequence
	AST_GATE_CAUSE: assert property (gate_enable_out |-> $past(torque_enable_in) == 2'b11)
		else $error("gate enabled without both channels");
	AST_GATE_ON: assert property (torque_enable_in == 2'b11 && !locked_out && !internal_fault_in |=> gate_enable_out)
		else $error("gate not enabled");
	AST_CUTOFF: assert property (torque_enable_in == 2'b00 |=> !gate_enable_out && cutoff_state_indicator_out)
		else $error("cut-off not entered");
	AST_INDICATOR: assert property (cutoff_state_indicator_out != gate_enable_out)
		else $error("indicator wrong");
	AST_NO_BRAKE: assert property (!brake_drive_out)
		else $error("brake driven");
	AST_FAULT_LOCK: assert property (internal_fault_in |=> locked_out && !gate_enable_out)
		else $error("fault did not lock");
	AST_LOCK_GATE: assert property (locked_out |-> !gate_enable_out)
		else $error("gate on while locked");
	AST_LOCK_HOLDS: assert property (disable iff (power_on_reset_in) locked_out |=> locked_out)
		else $error("lock released");
	AST_SKEW_TOL: assert property (s_warn |-> mis_cnt >= dtm_pkg::SKEW_TOL_MS * CYC_PER_MS)
		else $error("warning too early");
	AST_WARN_CODE: assert property (s_warn |-> error_code_out == dtm_pkg::ERR_SKEW_WARN)
		else $error("warning code wrong");
	AST_SHUT_WIN: assert property (s_diag_shut |-> warn_age >= dtm_pkg::SHUT_MIN_MS * CYC_PER_MS
		&& warn_age <= dtm_pkg::SHUT_MAX_MS * CYC_PER_MS)
		else $error("shutdown outside window");
	AST_SHUT_CODE: assert property (s_shut |-> locked_out && error_code_out == dtm_pkg::ERR_DIAG_SHUT)
		else $error("shutdown code wrong");
	AST_SHUT_MAX: assert property (mis_cnt == dtm_pkg::MISMATCH_MAX_MS * CYC_PER_MS |-> locked_out)
		else $error("shutdown too late");
	AST_STICKY: assert property (disable iff (power_on_reset_in) (error_out & $past(error_out)) == $past(error_out))
		else $error("error flag lost");
endmodule // dtm_monitor_props

bind dtm_monitor dtm_monitor_props #(.CYC_PER_MS(CYC_PER_MS)) i_dtm_monitor_props (.clock_in(clock_in),
	.reset_in(reset_in), .power_on_reset_in(power_on_reset_in), .torque_enable_in(torque_enable_in),
	.travel_in(travel_in), .internal_fault_in(internal_fault_in), .gate_enable_out(gate_enable_out),
	.brake_drive_out(brake_drive_out), .cutoff_state_indicator_out(cutoff_state_indicator_out),
	.locked_out(locked_out), .error_out(error_out), .error_code_out(error_code_out));

// *** dtm_ctrl_model.sv ***
/*
 * Lift controller model: two relays and the travel signal.
 * Assumes commands from the bench; drives at the falling edge.
 */
`timescale 1ns/1ps
module dtm_ctrl_model (
	// Clock
	input wire logic clock_in,
	// Commands
	input wire logic enable_req_in,
	input wire logic travel_req_in,
	input wire logic stuck_a_in,
	input wire logic [15:0] skew_cyc_in,
	// Lines to the monitor
	output dtm_pkg::dtm_chan_t torque_enable_out,
	output logic travel_out
);
	logic [15:0] lag;
	initial begin
		torque_enable_out = 2'b00;
		travel_out = 1'b0;
		lag = 16'h0000;
	end
	// Relay B lags relay A to mimic a slow contact; relay A may weld shut
	always @(negedge clock_in) begin
		travel_out <= travel_req_in;
		torque_enable_out.chan_a <= enable_req_in | stuck_a_in;
		if (torque_enable_out.chan_b == enable_req_in) begin
			lag <= 16'h0000;
		end else if (lag >= skew_cyc_in) begin
			torque_enable_out.chan_b <= enable_req_in;
		end else begin
			lag <= lag + 16'h0001;
		end
	end
endmodule // dtm_ctrl_model

// *** dtm_monitor_tb.sv ***
/*
 * Testbench for dtm_monitor: journeys, plausibility errors, stuck relay, fault.
 * Assumes a shortened millisecond of CPM cycles.
 */
`timescale 1ns/1ps
module dtm_monitor_tb;
	localparam int CPM = 8;
	logic clock_in = 1'b0;
	logic reset_in, por, en_req, tr_req, stuck_a, fault, travel, gate, brake, cutoff, locked;
	logic [15:0] skew;
	logic [9:0] code, exp_code;
	dtm_pkg::dtm_chan_t chan;
	dtm_pkg::dtm_err_t err, exp_err;
	int fails = 0;
	int total_checks = 0;
	int seed = 32'h745715B5;
	always #5 clock_in = ~clock_in;
	dtm_ctrl_model i_dtm_ctrl_model (.clock_in(clock_in), .enable_req_in(en_req), .travel_req_in(tr_req),
		.stuck_a_in(stuck_a), .skew_cyc_in(skew), .torque_enable_out(chan), .travel_out(travel));
	dtm_monitor #(.CYC_PER_MS(CPM)) i_dtm_monitor (.clock_in(clock_in), .reset_in(reset_in),
		.power_on_reset_in(por), .torque_enable_in(chan), .travel_in(travel), .internal_fault_in(fault),
		.gate_enable_out(gate), .brake_drive_out(brake), .cutoff_state_indicator_out(cutoff),
		.locked_out(locked), .error_out(err), .error_code_out(code));
	// ************************************************************
	// Tasks
	// ************************************************************
	task wait_ms(input int n);
		repeat (n * CPM) @(negedge clock_in);
	endtask
	task chk(input logic [9:0] got, input logic [9:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task cmp_err();
		chk({4'h0, err}, {4'h0, exp_err});
		chk(code, exp_code);
	endtask
	// Quiet until lo, then the flag and code must have appeared by hi
	task expect_err(input int lo, input int hi, input logic [5:0] m, input logic [9:0] c);
		wait_ms(lo);
		cmp_err();
		wait_ms(hi - lo);
		exp_err = exp_err | m;
		exp_code = c;
		cmp_err();
	endtask
	task pulse(input logic power);
		if (power) por <= 1'b1;
		else reset_in <= 1'b1;
		repeat (2) @(negedge clock_in);
		por <= 1'b0;
		reset_in <= 1'b0;
		@(negedge clock_in);
	endtask
	task close_out();
		$display("checks %0d errors %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// ************************************************************
	// Sequence
	// ************************************************************
	initial begin
		{reset_in, por, en_req, tr_req, stuck_a, fault} = 6'h30;
		skew = 16'h0000;
		exp_err = 6'h00;
		exp_code = dtm_pkg::ERR_NONE;
		repeat (6) @(negedge clock_in);
		reset_in <= 1'b0;
		por <= 1'b0;
		skew <= 16'($unsigned($random(seed)) % (100 * CPM));
		tr_req <= 1'b1;
		en_req <= 1'b1;
		wait_ms(200);
		chk({9'h000, gate}, 10'h001);
		tr_req <= 1'b0;
		en_req <= 1'b0;
		wait_ms(200);
		chk({8'h00, cutoff, brake}, 10'h002);
		cmp_err();
		skew <= 16'h0000;
		tr_req <= 1'b1;
		en_req <= 1'b1;
		wait_ms(100);
		en_req <= 1'b0;
		expect_err(190, 210, 6'h01, dtm_pkg::ERR_INTERRUPT);
		tr_req <= 1'b0;
		wait_ms(10);
		tr_req <= 1'b1;
		expect_err(2490, 2510, 6'h08, dtm_pkg::ERR_REMAINS);
		en_req <= 1'b1;
		wait_ms(100);
		tr_req <= 1'b0;
		expect_err(2490, 2510, 6'h04, dtm_pkg::ERR_MISSING);
		en_req <= 1'b0;
		wait_ms(10);
		en_req <= 1'b1;
		expect_err(2490, 2510, 6'h02, dtm_pkg::ERR_NO_TRAVEL);
		en_req <= 1'b0;
		wait_ms(10);
		pulse(1'b0);
		cmp_err();
		stuck_a <= 1'b1;
		expect_err(118, 125, 6'h20, dtm_pkg::ERR_SKEW_WARN);
		wait_ms(185);
		chk({9'h000, locked}, 10'h000);
		wait_ms(1290);
		exp_err = exp_err | 6'h10;
		exp_code = dtm_pkg::ERR_DIAG_SHUT;
		cmp_err();
		stuck_a <= 1'b0;
		pulse(1'b0);
		en_req <= 1'b1;
		wait_ms(10);
		chk({8'h00, locked, gate}, 10'h002);
		en_req <= 1'b0;
		pulse(1'b1);
		exp_err = 6'h00;
		exp_code = dtm_pkg::ERR_NONE;
		cmp_err();
		fault <= 1'b1;
		@(negedge clock_in);
		fault <= 1'b0;
		repeat (2) @(negedge clock_in);
		chk({9'h000, locked}, 10'h001);
		close_out();
	end
	// A hang beyond the planned span counts as a failure
	initial begin
		#1_000_000;
		fails++;
		close_out();
	end
endmodule // dtm_monitor_tb
